// [hdl/sec_eeprom.sv]
// Two-wire bus slave command layer of a 128 x 8 reprogrammable memory
`timescale 1ns/1ps
`default_nettype none
module sec_eeprom #(
  parameter int unsigned P_PROG_CYCLES = sec_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Two-wire bus
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Select straps
  input wire logic i_select_input_high,
  input wire logic i_select_input_mid,
  input wire logic i_select_input_low,
  // Status
  output logic o_prog_busy
);
  import sec_pkg::*;

  sec_buf_if q ();
  sec_buf u_buf (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .q(q)
  );

  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r;
  logic [2:0] sel_s1_r, sel_s2_r;
  sec_state_t state_r;
  logic [3:0] cnt_r;
  logic [6:0] sh_r;
  logic ack_want_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] tx_r;
  logic oe_r;
  logic sda_out_r;
  logic push_r;
  logic abort_r;
  logic busy_r;
  logic [CNT_W-1:0] tmr_r;
  logic [ADDR_W-1:0] pa_r;
  logic [DATA_W-1:0] pd_r;
  logic [DATA_W-1:0] mem_r [WORDS];
  logic scl_rise, scl_fall, start_c, stop_c, byte_done, busy_any;
  logic [7:0] byte_in;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges are taken only from the second stage onward
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'h7;
      sel_s1_r <= 3'h0;
      sel_s2_r <= 3'h0;
    end else begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= {i_scl, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_s3_r} <= {i_sda_in, sda_s1_r, sda_s2_r};
      sel_s1_r <= {i_select_input_high, i_select_input_mid, i_select_input_low};
      sel_s2_r <= sel_s1_r;
    end
  end

  assign scl_rise = scl_s2_r && !scl_s3_r;
  assign scl_fall = !scl_s2_r && scl_s3_r;
  assign start_c = scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
  assign stop_c = scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;
  assign byte_in = {sh_r, sda_s2_r};
  assign byte_done = scl_rise && (state_r != ST_IDLE) && (cnt_r == CLK_LAST_BIT);
  // Queued requests count as programming so polling sees them too
  assign busy_any = busy_r || q.out_valid || push_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 7'h00;
      ack_want_r <= 1'b0;
      addr_r <= 7'h00;
      wdata_r <= 8'h00;
      abort_r <= 1'b0;
    end else begin
      abort_r <= 1'b0;
      if (start_c) begin
        state_r <= ST_SEL;
        cnt_r <= 4'h0;
        ack_want_r <= 1'b0;
      end else if (stop_c) begin
        state_r <= ST_IDLE;
        cnt_r <= 4'h0;
        ack_want_r <= 1'b0;
      end else if (scl_rise && state_r != ST_IDLE) begin
        if (cnt_r != CLK_ACK) begin
          sh_r <= byte_in[6:0];
          cnt_r <= 4'(cnt_r + 4'h1);
          if (cnt_r == CLK_LAST_BIT) begin
            unique case (state_r)
              ST_SEL: begin
                if (!sec_sel_match(byte_in, sel_s2_r)) begin
                  state_r <= ST_SKIP;
                end else if (!byte_in[0]) begin
                  ack_want_r <= 1'b1;
                  abort_r <= 1'b1;
                  state_r <= ST_ADDR;
                end else if (busy_any) begin
                  state_r <= ST_SKIP;
                end else begin
                  ack_want_r <= 1'b1;
                  state_r <= ST_RDATA;
                end
              end
              ST_ADDR: begin
                // Bit 7 of the address has no word behind it in 128 words
                addr_r <= byte_in[ADDR_W-1:0];
                ack_want_r <= 1'b1;
                state_r <= ST_WDATA;
              end
              ST_WDATA: begin
                wdata_r <= byte_in;
                ack_want_r <= 1'b1;
                state_r <= ST_WDONE;
              end
              ST_WDONE: begin
                state_r <= ST_SKIP;
              end
              ST_IDLE, ST_RDATA, ST_SKIP: begin
                state_r <= state_r;
              end
            endcase
          end
        end else begin
          cnt_r <= 4'h0;
          ack_want_r <= 1'b0;
          if (state_r == ST_RDATA && !ack_want_r) begin
            if (!sda_s2_r) begin
              addr_r <= 7'(addr_r + 7'h01);
            end else begin
              state_r <= ST_SKIP;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line driver: acknowledge and read bits change on the clock's fall
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_r <= 1'b0;
      tx_r <= 8'h00;
      sda_out_r <= 1'b0;
    end else if (start_c || stop_c) begin
      oe_r <= 1'b0;
    end else if (scl_fall) begin
      if (cnt_r == CLK_ACK) begin
        oe_r <= ack_want_r;
      end else if (state_r == ST_RDATA) begin
        oe_r <= ~tx_r[7];
        tx_r <= {tx_r[6:0], 1'b1};
      end else begin
        oe_r <= 1'b0;
      end
    end else if (scl_rise && state_r == ST_RDATA && cnt_r == CLK_ACK) begin
      if (ack_want_r) begin
        tx_r <= mem_r[addr_r];
      end else if (!sda_s2_r) begin
        tx_r <= mem_r[7'(addr_r + 7'h01)];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request hand-off: held until the buffer accepts it
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      push_r <= 1'b0;
    end else if (stop_c && state_r == ST_WDONE && cnt_r <= 4'h1) begin
      // The stop's own clock rise has already been counted when the stop is seen
      push_r <= 1'b1;
    end else if (q.in_ready) begin
      push_r <= 1'b0;
    end
  end

  assign q.in_valid = push_r;
  assign q.in_data = {addr_r, wdata_r};
  assign q.out_ready = !busy_r;

  ////////////////////////////////////////////////////////////////////////////
  // Timed erase then write; an abort leaves the word erased
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_r <= 1'b0;
      tmr_r <= '0;
      pa_r <= 7'h00;
      pd_r <= 8'h00;
      for (int i = 0; i < WORDS; i++) begin
        mem_r[i] <= ERASED;
      end
    end else if (abort_r) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      tmr_r <= CNT_W'(tmr_r - 1'b1);
      if (tmr_r == CNT_W'(1)) begin
        busy_r <= 1'b0;
        mem_r[pa_r] <= pd_r;
      end
    end else if (q.out_valid) begin
      busy_r <= 1'b1;
      tmr_r <= CNT_W'(P_PROG_CYCLES);
      {pa_r, pd_r} <= q.out_data;
      mem_r[q.out_data[REQ_W-1:DATA_W]] <= ERASED;
    end
  end

  assign o_sda_oe = oe_r;
  assign o_sda_out = sda_out_r;
  assign o_prog_busy = busy_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  ack_drive_a: assert property (scl_fall && cnt_r == CLK_ACK && ack_want_r && !start_c && !stop_c
    |=> o_sda_oe) else $error("acknowledge not driven");
  ack_free_a: assert property (scl_fall && cnt_r == 4'h0 && state_r != ST_RDATA && !start_c && !stop_c
    |=> !o_sda_oe) else $error("line not freed after acknowledge");
  rd_release_a: assert property (scl_fall && cnt_r == CLK_ACK && state_r == ST_RDATA && !ack_want_r
    && !start_c && !stop_c |=> !o_sda_oe) else $error("line held on master acknowledge");
  sel_miss_a: assert property (byte_done && state_r == ST_SEL && !sec_sel_match(byte_in, sel_s2_r)
    |=> state_r == ST_SKIP && !ack_want_r) else $error("foreign select answered");
  poll_busy_a: assert property (byte_done && state_r == ST_SEL && sec_sel_match(byte_in, sel_s2_r)
    && byte_in[0] && busy_any |=> !ack_want_r) else $error("read select answered while busy");
  abort_prog_a: assert property (byte_done && state_r == ST_SEL && sec_sel_match(byte_in, sel_s2_r)
    && !byte_in[0] && busy_r |-> ##2 !busy_r) else $error("programming not aborted");
  stop_start_a: assert property (stop_c && state_r == ST_WDONE && cnt_r <= 4'h1 && !busy_r
    && !q.out_valid |-> ##[1:3] busy_r) else $error("stop did not start programming");
  addr_step_a: assert property (scl_rise && state_r == ST_RDATA && cnt_r == CLK_ACK && !ack_want_r
    && !sda_s2_r && !start_c && !stop_c |=> addr_r == 7'($past(addr_r) + 7'h01))
    else $error("address not advanced");
  rd_load_a: assert property (scl_rise && state_r == ST_RDATA && cnt_r == CLK_ACK && ack_want_r
    && !start_c && !stop_c && !busy_r |=> tx_r == mem_r[addr_r]) else $error("read data not loaded");
  nack_end_a: assert property (scl_rise && state_r == ST_RDATA && cnt_r == CLK_ACK && !ack_want_r
    && sda_s2_r && !start_c && !stop_c |=> state_r == ST_SKIP) else $error("read went on after nack");

  write_cv: cover property (stop_c && state_r == ST_WDONE && cnt_r <= 4'h1);
  read_cv: cover property (scl_rise && state_r == ST_RDATA && cnt_r == CLK_ACK && !sda_s2_r);
  poll_cv: cover property (byte_done && state_r == ST_SEL && byte_in[0] && busy_any);
  done_cv: cover property (busy_r ##1 !busy_r);
endmodule : sec_eeprom
`default_nettype wire

// [hdl/sec_pkg.sv]
// Shared constants and types for the serial memory command layer
package sec_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned PROG_TIME_US = 10000;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int CNT_W = 21;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int WORDS = 128;
  localparam int REQ_W = ADDR_W + DATA_W;
  localparam logic [3:0] SEL_TAG = 4'hA;
  localparam logic [3:0] CLK_LAST_BIT = 4'h7;
  localparam logic [3:0] CLK_ACK = 4'h8;
  localparam logic [7:0] ERASED = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SEL   = 3'b001,
    ST_ADDR  = 3'b010,
    ST_WDATA = 3'b011,
    ST_WDONE = 3'b100,
    ST_RDATA = 3'b101,
    ST_SKIP  = 3'b110
  } sec_state_t;

  // Fixed pattern 1010 followed by the three select levels, high bit first
  function automatic logic sec_sel_match(input logic [7:0] b, input logic [2:0] s);
    return (b[7:4] == SEL_TAG) && (b[3:1] == s);
  endfunction : sec_sel_match
endpackage : sec_pkg

// [hdl/sec_buf_if.sv]
// Valid/ready carrier between the command layer and its request buffer
`timescale 1ns/1ps
`default_nettype none
interface sec_buf_if;
  import sec_pkg::*;
  logic in_valid;
  logic in_ready;
  logic [REQ_W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [REQ_W-1:0] out_data;
  modport buf_mp (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
  modport user_mp (output in_valid, output in_data, output out_ready,
                   input in_ready, input out_valid, input out_data);
endinterface : sec_buf_if
`default_nettype wire

// [hdl/sec_buf.sv]
// Two-entry buffer holding pending program requests
`timescale 1ns/1ps
`default_nettype none
module sec_buf (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Request stream
  sec_buf_if.buf_mp q
);
  import sec_pkg::*;

  logic [REQ_W-1:0] ent_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign q.in_ready = (cnt_r != 2'h2);
  assign q.out_valid = (cnt_r != 2'h0);
  assign q.out_data = ent_r[rd_ptr_r];
  assign push = q.in_valid && q.in_ready;
  assign pop = q.out_valid && q.out_ready;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ent_r[0] <= '0;
      ent_r[1] <= '0;
      wr_ptr_r <= 1'b0;
    end else if (push) begin
      ent_r[wr_ptr_r] <= q.in_data;
      wr_ptr_r <= ~wr_ptr_r;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule : sec_buf
`default_nettype wire

// [verification/sec_master.sv]
// Bus master model that drives the bus clock and its side of the data line
`timescale 1ns/1ps
`default_nettype none
module sec_master (
  // Bus pins
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda_w
);
  // Quarter of a 125 ns bus clock; data bits move mid-low, far from clock edges, and start and stop move the line with the clock high
  localparam realtime Q = 31.25;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic bit_x(input logic b, output logic r);
    #Q o_sda = b;
    #Q o_scl = 1'b1;
    #Q r = i_sda_w;
    #Q o_scl = 1'b0;
  endtask : bit_x
  // Also a repeated start when entered with the clock low
  task automatic start;
    #Q o_sda = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b0;
  endtask : start
  // Clock is left high so it stands still between frames
  task automatic stop;
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b1;
    #Q;
  endtask : stop
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, ack);
  endtask : wr_byte
  // Line released while the memory talks; own acknowledge on the ninth clock
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(mack, r);
  endtask : rd_byte
endmodule : sec_master
`default_nettype wire

// [verification/serial_eeprom_control_words_tb.sv]
// Self-checking bench for the serial memory command layer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("Error t=%0t got=%0h exp=%0h", $time, a, e); end end
module serial_eeprom_control_words_tb;
  import sec_pkg::*;
  localparam logic [2:0] STRAPS = 3'h5;
  logic clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic scl;
  logic m_sda;
  wire logic sda_w;
  logic o_sda_out;
  logic o_sda_oe;
  logic o_prog_busy;
  logic ack;
  logic [7:0] d;
  int bad_count = 0;
  int comparisons = 0;
  // Open-drain wire with pull-up: low when either side pulls
  assign sda_w = m_sda & ~(o_sda_oe & ~o_sda_out);
  initial forever #2.5 clk = ~clk;
  sec_master m (.o_scl(scl), .o_sda(m_sda), .i_sda_w(sda_w));
  // Long enough that a poll lands inside programming
  sec_eeprom #(.P_PROG_CYCLES(2000)) i_dut (.i_ref_clk(clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda_in(sda_w),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_select_input_high(STRAPS[2]),
    .i_select_input_mid(STRAPS[1]), .i_select_input_low(STRAPS[0]), .o_prog_busy(o_prog_busy));
  ////////////////////////////////////////////////////////////////
  task automatic sel_addr(input logic [6:0] a);
    m.start;
    m.wr_byte({4'hA, STRAPS, 1'b0}, ack);
    `CHK(ack, 1'b0)
    m.wr_byte({1'b0, a}, ack);
    `CHK(ack, 1'b0)
  endtask : sel_addr
  task automatic write_word(input logic [6:0] a, input logic [7:0] v);
    sel_addr(a);
    m.wr_byte(v, ack);
    `CHK(ack, 1'b0)
    m.stop;
  endtask : write_word
  task automatic read_sel(input logic e);
    m.start;
    m.wr_byte({4'hA, STRAPS, 1'b1}, ack);
    `CHK(ack, e)
  endtask : read_sel
  task automatic wait_idle;
    int n = 0;
    while (o_prog_busy !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    `CHK(o_prog_busy, 1'b0)
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////
  task automatic t_write_poll;
    write_word(7'h00, 8'h3C);
    repeat (8) @(negedge clk);
    `CHK(o_prog_busy, 1'b1)
    read_sel(1'b1);
    m.stop;
    wait_idle;
    read_sel(1'b0);
    m.rd_byte(1'b1, d);
    `CHK(d, 8'h3C)
    m.stop;
  endtask : t_write_poll
  task automatic t_wrap_read;
    write_word(7'h7F, 8'h5A);
    wait_idle;
    sel_addr(7'h7F);
    read_sel(1'b0);
    m.rd_byte(1'b0, d);
    `CHK(d, 8'h5A)
    m.rd_byte(1'b0, d);
    `CHK(d, 8'h3C)
    m.rd_byte(1'b1, d);
    `CHK(d, ERASED)
    m.stop;
  endtask : t_wrap_read
  // Wrong select bits, then a wrong fixed pattern
  task automatic t_mismatch;
    logic [7:0] w[2] = '{{4'hA, 3'h2, 1'b0}, {4'h5, STRAPS, 1'b0}};
    for (int i = 0; i < 2; i++) begin
      m.start;
      m.wr_byte(w[i], ack);
      `CHK(ack, 1'b1)
      m.stop;
    end
  endtask : t_mismatch
  task automatic t_abort;
    write_word(7'h10, 8'h00);
    repeat (8) @(posedge clk);
    m.start;
    m.wr_byte({4'hA, STRAPS, 1'b0}, ack);
    `CHK(ack, 1'b0)
    m.stop;
    repeat (8) @(negedge clk);
    `CHK(o_prog_busy, 1'b0)
    sel_addr(7'h10);
    read_sel(1'b0);
    m.rd_byte(1'b1, d);
    `CHK(d, ERASED)
    m.stop;
  endtask : t_abort
  // Stop after the address byte must start nothing
  task automatic t_short;
    sel_addr(7'h20);
    m.stop;
    repeat (8) @(negedge clk);
    `CHK(o_prog_busy, 1'b0)
  endtask : t_short
  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 i_rst_n = 1'b1;
    repeat (10) @(posedge clk);
    t_write_poll;
    t_wrap_read;
    t_mismatch;
    t_abort;
    t_short;
    test_done;
  end
endmodule : serial_eeprom_control_words_tb
`default_nettype wire
